// ### core/midi_codec_map.vh
`ifndef MIDI_CODEC_MAP_VH
`define MIDI_CODEC_MAP_VH
// status kinds, upper nibble of a status byte
`define KIND_NOTE_OFF 4'h8
`define KIND_NOTE_ON 4'h9
`define KIND_KEY_PRESS 4'hA
`define KIND_CTRL 4'hB
`define KIND_PROGRAM 4'hC
`define KIND_CHAN_PRESS 4'hD
`define KIND_PITCH 4'hE
`define KIND_SYSTEM 4'hF
// system status bytes
`define SYS_EXCL_START 8'hF0
`define SYS_EXCL_END 8'hF7
`define SYS_REALTIME_MIN 8'hF8
// channel mode and bank select controller numbers
`define CTRL_MODE_FIRST 7'h78
`define CTRL_RESET_ALL 7'h79
`define CTRL_LOCAL 7'h7A
`define CTRL_OMNI_OFF 7'h7C
`define CTRL_OMNI_ON 7'h7D
`define CTRL_MONO_ON 7'h7E
`define CTRL_POLY_ON 7'h7F
`define CTRL_BANK_MSB 7'h00
`define CTRL_BANK_LSB 7'h20
// reset values and status bit position
`define PITCH_CENTRE 14'h2000
`define STATUS_BIT 7
`endif

// ### core/midi_channel_message_codec.v
// Function
// RL1 - channel sits in status low nibble; 0-15 mean channels 1-16
// RL2 - note release is 1000nnnn, key byte, release velocity byte
// RL3 - key press is 1001nnnn, key byte, then velocity byte
// RL4 - per-key pressure is 1010nnnn, key byte, then pressure byte
// RL5 - controller change 1011nnnn, number and value; 120-127 are mode
// RL6 - mode 121 resets controllers, 122 local, 124-127 omni and poly/mono
// RL7 - program change is 1100nnnn with exactly one data byte
// RL8 - channel pressure 1101nnnn, one byte, greatest held key pressure
// RL9 - pitch wheel 1110nnnn, 14 bits, low seven first, 2000H centre
// RL10 - bank select controllers may precede program change, 16384 banks
// RL11 - status may be omitted when equal; receiver reuses last status
// RL12 - key press with velocity zero is treated as note release
// RL13 - system messages carry no channel, handled regardless of channel
// RL14 - exclusive message first data byte is maker identification
// RL15 - receiver keeps exclusive only if identification matches its own
// RL16 - status bytes have bit 7 set, data bytes bit 7 clear
`timescale 1ns/1ps
`include "midi_codec_map.vh"
module midi_channel_message_codec #(
  parameter [6:0] OWN_MAKER_ID = 7'h7D, // arbitrary value
  parameter [3:0] LISTEN_CHANNEL = 4'h0,
  parameter NUM_KEYS = 128
)(
  // clock and reset
  input wire clock,
  input wire nrst,
  // transmit request
  input wire tx_req,
  input wire [3:0] tx_kind,
  input wire [3:0] tx_channel,
  input wire [6:0] tx_data1,
  input wire [6:0] tx_data2,
  input wire [13:0] tx_pitch,
  input wire tx_release_as_press,
  output wire tx_ready,
  // transmit byte stream
  output reg tx_byte_valid,
  output reg [7:0] tx_byte,
  input wire tx_byte_ready,
  // receive byte stream
  input wire rx_byte_valid,
  input wire [7:0] rx_byte,
  // decoded channel message
  output reg msg_valid,
  output reg [3:0] msg_kind,
  output reg [3:0] msg_channel,
  output reg [6:0] msg_data1,
  output reg [6:0] msg_data2,
  output reg [13:0] msg_pitch,
  output reg msg_mode,
  output reg msg_bank,
  // decoded system traffic
  output reg sys_valid,
  output reg [7:0] sys_status,
  output reg excl_valid,
  output reg [6:0] excl_data,
  output reg excl_done,
  // channel state
  output reg [13:0] bank,
  output reg local_on,
  output reg omni_on,
  output reg mono_on,
  output reg ctrl_reset,
  output reg [6:0] chan_pressure
);

  // ===========================================
  // helpers
  function [1:0] data_count;
    input [3:0] kind;
    begin
      if (kind == `KIND_PROGRAM || kind == `KIND_CHAN_PRESS) // [RL7] [RL8]
        data_count = 2'd1;
      else
        data_count = 2'd2;
    end
  endfunction

  // ===========================================
  // per-key pressure table, for channel pressure
  reg [6:0] key_press [0:NUM_KEYS-1];
  reg [6:0] max_press;
  integer k;
  integer clr;
  always @*
  begin
    max_press = 7'h00;
    for (k = 0; k < NUM_KEYS; k = k + 1)
      if (key_press[k] > max_press)
        max_press = key_press[k]; // [RL8]
  end

  // ===========================================
  // transmitter
  localparam TX_IDLE = 2'd0;
  localparam TX_STAT = 2'd1;
  localparam TX_D1 = 2'd2;
  localparam TX_D2 = 2'd3;
  reg [1:0] tx_state;
  // reset value 00 never equals a real status, so no valid flag
  reg [7:0] last_tx_status;
  reg [6:0] t_d1;
  reg [6:0] t_d2;
  reg [1:0] t_count;
  reg [7:0] next_stat;
  reg [6:0] next_d1;
  reg [6:0] next_d2;

  assign tx_ready = (tx_state == TX_IDLE) && !tx_byte_valid;

  always @*
  begin
    next_stat = {tx_kind, tx_channel}; // [RL1]
    next_d1 = tx_data1;
    next_d2 = tx_data2;
    case (tx_kind)
      `KIND_NOTE_OFF:
        if (tx_release_as_press)
        begin
          next_stat = {`KIND_NOTE_ON, tx_channel}; // [RL12]
          next_d2 = 7'h00;
        end
      `KIND_CHAN_PRESS:
        next_d1 = max_press; // [RL8]
      `KIND_PITCH:
      begin
        next_d1 = tx_pitch[6:0]; // [RL9]
        next_d2 = tx_pitch[13:7];
      end
      default:
        next_d1 = tx_data1; // [RL2] [RL3] [RL4] [RL5] [RL7]
    endcase
  end

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_state <= TX_IDLE;
      tx_byte_valid <= 1'b0;
      tx_byte <= 8'h00;
      last_tx_status <= 8'h00;
      t_d1 <= 7'h00;
      t_d2 <= 7'h00;
      t_count <= 2'd0;
      for (clr = 0; clr < NUM_KEYS; clr = clr + 1)
        key_press[clr] <= 7'h00;
    end
    else
    begin
      if (tx_req && tx_ready)
      begin
        // keep pressure table of held keys
        if (tx_kind == `KIND_NOTE_ON && tx_data2 != 7'h00)
          key_press[tx_data1] <= 7'h01;
        else if (tx_kind == `KIND_NOTE_OFF ||
                 tx_kind == `KIND_NOTE_ON)
          key_press[tx_data1] <= 7'h00;
        else if (tx_kind == `KIND_KEY_PRESS)
          key_press[tx_data1] <= tx_data2;
      end
      case (tx_state)
        TX_IDLE:
          // kinds below 8 would put out a status without bit 7
          if (tx_req && tx_ready && tx_kind[3] &&
              tx_kind != `KIND_SYSTEM) // [RL16]
          begin
            t_d1 <= next_d1;
            t_d2 <= next_d2;
            t_count <= data_count(next_stat[7:4]);
            tx_byte_valid <= 1'b1;
            if (next_stat == last_tx_status)
            begin
              tx_byte <= {1'b0, next_d1}; // [RL11]
              tx_state <= TX_D1;
            end
            else
            begin
              tx_byte <= next_stat; // [RL16]
              tx_state <= TX_STAT;
              last_tx_status <= next_stat;
            end
          end
        TX_STAT:
          if (tx_byte_ready)
          begin
            tx_byte <= {1'b0, t_d1};
            tx_state <= TX_D1;
          end
        TX_D1:
          if (tx_byte_ready)
          begin
            if (t_count == 2'd2)
            begin
              tx_byte <= {1'b0, t_d2};
              tx_state <= TX_D2;
            end
            else
            begin
              tx_byte_valid <= 1'b0;
              tx_state <= TX_IDLE;
            end
          end
        TX_D2:
          if (tx_byte_ready)
          begin
            tx_byte_valid <= 1'b0;
            tx_state <= TX_IDLE;
          end
        default:
          tx_state <= TX_IDLE;
      endcase
    end
  end

  // ===========================================
  // receiver
  // run_status with bit 7 low means no running status
  reg [7:0] run_status;
  reg have_d1;
  reg [6:0] r_d1;
  reg in_excl;
  reg excl_id_seen;
  reg excl_match;
  wire [3:0] r_kind = run_status[7:4];
  wire [6:0] r_d = rx_byte[6:0];
  wire is_status = rx_byte[`STATUS_BIT]; // [RL16]
  wire done_msg = have_d1 || data_count(r_kind) == 2'd1;
  // channel filter only on data bytes of channel messages
  wire chan_hit = omni_on || run_status[3:0] == LISTEN_CHANNEL;

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      run_status <= 8'h00;
      have_d1 <= 1'b0;
      r_d1 <= 7'h00;
      in_excl <= 1'b0;
      excl_id_seen <= 1'b0;
      excl_match <= 1'b0;
      msg_valid <= 1'b0;
      msg_kind <= 4'h0;
      msg_channel <= 4'h0;
      msg_data1 <= 7'h00;
      msg_data2 <= 7'h00;
      msg_pitch <= `PITCH_CENTRE;
      msg_mode <= 1'b0;
      msg_bank <= 1'b0;
      sys_valid <= 1'b0;
      sys_status <= 8'h00;
      excl_valid <= 1'b0;
      excl_data <= 7'h00;
      excl_done <= 1'b0;
      bank <= 14'h0000;
      local_on <= 1'b1;
      omni_on <= 1'b1;
      mono_on <= 1'b0;
      ctrl_reset <= 1'b0;
      chan_pressure <= 7'h00;
    end
    else
    begin
      msg_valid <= 1'b0;
      sys_valid <= 1'b0;
      excl_valid <= 1'b0;
      excl_done <= 1'b0;
      ctrl_reset <= 1'b0;
      if (rx_byte_valid && is_status && rx_byte[7:4] == `KIND_SYSTEM)
      begin
        sys_valid <= 1'b1; // [RL13]
        sys_status <= rx_byte;
        // real-time may interleave anything, so only common kills status
        if (rx_byte < `SYS_REALTIME_MIN)
        begin
          run_status <= 8'h00;
          have_d1 <= 1'b0;
          excl_done <= in_excl && excl_match && rx_byte == `SYS_EXCL_END;
          in_excl <= rx_byte == `SYS_EXCL_START;
          excl_id_seen <= 1'b0;
          excl_match <= 1'b0;
        end
      end
      else if (rx_byte_valid && is_status)
      begin
        run_status <= rx_byte; // [RL16]
        have_d1 <= 1'b0;
        in_excl <= 1'b0;
      end
      else if (rx_byte_valid && in_excl)
      begin
        excl_id_seen <= 1'b1; // [RL14]
        if (!excl_id_seen)
          excl_match <= r_d == OWN_MAKER_ID; // [RL15]
        excl_valid <= excl_id_seen && excl_match;
        if (excl_id_seen && excl_match)
          excl_data <= r_d;
      end
      else if (rx_byte_valid && run_status[`STATUS_BIT])
      begin
        r_d1 <= r_d;
        // data bytes after completion reuse status
        have_d1 <= !done_msg; // [RL11]
        if (done_msg && chan_hit)
        begin
          msg_valid <= 1'b1;
          msg_channel <= run_status[3:0]; // [RL1]
          msg_kind <= r_kind;
          msg_data1 <= have_d1 ? r_d1 : r_d; // [RL7] [RL8]
          msg_data2 <= have_d1 ? r_d : 7'h00; // [RL2] [RL3] [RL4]
          msg_mode <= r_kind == `KIND_CTRL &&
                      r_d1 >= `CTRL_MODE_FIRST; // [RL5]
          msg_bank <= r_kind == `KIND_CTRL &&
                      (r_d1 == `CTRL_BANK_MSB ||
                       r_d1 == `CTRL_BANK_LSB); // [RL10]
          if (r_kind == `KIND_CHAN_PRESS)
            chan_pressure <= r_d; // [RL8]
          if (r_kind == `KIND_NOTE_ON && r_d == 7'h00)
            msg_kind <= `KIND_NOTE_OFF; // [RL12]
          if (r_kind == `KIND_PITCH)
            msg_pitch <= {r_d, r_d1}; // [RL9]
          if (r_kind == `KIND_CTRL)
          begin
            if (r_d1 == `CTRL_BANK_MSB)
              bank[13:7] <= r_d; // [RL10]
            if (r_d1 == `CTRL_BANK_LSB)
              bank[6:0] <= r_d;
            if (r_d1 == `CTRL_RESET_ALL)
            begin
              ctrl_reset <= 1'b1; // [RL6]
              msg_pitch <= `PITCH_CENTRE;
              chan_pressure <= 7'h00;
            end
            if (r_d1 == `CTRL_LOCAL)
              local_on <= r_d != 7'h00; // [RL6]
            // low bit of the code picks on versus off
            if (r_d1 == `CTRL_OMNI_OFF || r_d1 == `CTRL_OMNI_ON)
              omni_on <= r_d1[0]; // [RL6]
            if (r_d1 == `CTRL_MONO_ON || r_d1 == `CTRL_POLY_ON)
              mono_on <= !r_d1[0];
          end
        end
      end
    end
  end

endmodule // midi_channel_message_codec

// ### tb/midi_sink_model.sv
`timescale 1ns/1ps
module midi_sink_model (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // byte stream from the codec
  input wire logic tx_byte_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_byte_ready,
  // stall control
  input wire logic slow
);
  logic [7:0] got[$];
  logic [1:0] tick;
  // a slow receiver is ready one cycle in four to stretch the hold time
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      tick <= 2'h0;
      tx_byte_ready <= 1'b0;
    end
    else
    begin
      if (tx_byte_valid && tx_byte_ready)
        got.push_back(tx_byte);
      tick <= tick + 2'h1;
      tx_byte_ready <= !slow || (tick == 2'h3);
    end
  end
endmodule // midi_sink_model

// ### tb/midi_codec_asserts.sv
`timescale 1ns/1ps
module midi_codec_asserts (
  // clock and reset
  input wire logic clock, nrst,
  // transmit side
  input wire logic tx_req, tx_ready, tx_byte_valid, tx_byte_ready,
  input wire logic [3:0] tx_kind,
  input wire logic [7:0] tx_byte,
  // receive side
  input wire logic msg_valid, msg_mode, msg_bank, sys_valid,
  input wire logic ctrl_reset, local_on,
  input wire logic [3:0] msg_kind,
  input wire logic [6:0] msg_data1, msg_data2,
  input wire logic [7:0] sys_status
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // ====================
  // transmit
  a_byte_holds: assert property (tx_byte_valid && !tx_byte_ready
    |=> tx_byte_valid && $stable(tx_byte)) else $error("byte not held");
  a_req_answer: assert property (tx_req && tx_ready
    && tx_kind[3] && tx_kind != 4'hF |=> tx_byte_valid)
    else $error("no first byte");
  a_data_follows: assert property (tx_byte_valid && tx_byte_ready
    && tx_byte[7] |=> tx_byte_valid && !tx_byte[7])
    else $error("no data after status");
  a_busy_blocks: assert property (tx_byte_valid
    |-> !tx_ready) else $error("ready while busy");
  // ====================
  // receive
  a_velo_zero: assert property (msg_valid && msg_kind == 4'h9
    |-> msg_data2 != 7'h00) else $error("zero velocity press");
  a_mode_flag: assert property (msg_valid && msg_kind == 4'hB
    |-> msg_mode == (msg_data1 >= 7'h78)) else $error("mode flag");
  a_bank_flag: assert property (msg_valid && msg_kind == 4'hB
    |-> msg_bank == (msg_data1 == 7'h00 || msg_data1 == 7'h20))
    else $error("bank flag");
  a_reset_cause: assert property (ctrl_reset
    |-> msg_kind == 4'hB && msg_data1 == 7'h79) else $error("reset cause");
  a_local_follow: assert property (msg_valid && msg_kind == 4'hB
    && msg_data1 == 7'h7A |-> ##[0:1] local_on == (msg_data2 != 7'h00))
    else $error("local control");
  a_sys_kind: assert property (sys_valid
    |-> sys_status[7:4] == 4'hF) else $error("system status");
  a_voice_kind: assert property (msg_valid
    |-> msg_kind[3] && msg_kind != 4'hF) else $error("voice kind");
  c_note: cover property (msg_valid && msg_kind == 4'h9);
  c_stall: cover property (tx_byte_valid && !tx_byte_ready);
  c_sys: cover property (sys_valid);
endmodule // midi_codec_asserts
bind midi_channel_message_codec midi_codec_asserts chk (.clock, .nrst,
  .tx_req, .tx_ready, .tx_byte_valid, .tx_byte_ready, .tx_kind, .tx_byte,
  .msg_valid, .msg_mode, .msg_bank, .sys_valid, .ctrl_reset, .local_on,
  .msg_kind, .msg_data1, .msg_data2, .sys_status);

// ### tb/midi_channel_message_codec_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
$display("BAD %s exp %h got %h", n, e, g); end end
module midi_channel_message_codec_test;
  logic clock, nrst, req, rel, rv, slow;
  logic [3:0] kind, chan;
  logic [6:0] d1, d2, xl;
  logic [13:0] pitch;
  logic [7:0] rb;
  wire rdy, bv, br, mv, sv, xv, xd, lo, om, mo, cr, mm, mb;
  wire [3:0] mk, mc;
  wire [6:0] m1, m2, cp, xdat;
  wire [13:0] mp, bank;
  wire [7:0] ss, tb;
  int errors = 0, n_compared = 0, nm, ns, nx, nd, nr;
  midi_channel_message_codec dut (.clock, .nrst, .tx_req(req),
    .tx_kind(kind), .tx_channel(chan), .tx_data1(d1), .tx_data2(d2),
    .tx_pitch(pitch), .tx_release_as_press(rel), .tx_ready(rdy),
    .tx_byte_valid(bv), .tx_byte(tb), .tx_byte_ready(br),
    .rx_byte_valid(rv), .rx_byte(rb), .msg_valid(mv), .msg_kind(mk),
    .msg_channel(mc), .msg_data1(m1), .msg_data2(m2), .msg_pitch(mp),
    .msg_mode(mm), .msg_bank(mb), .sys_valid(sv), .sys_status(ss),
    .excl_valid(xv), .excl_data(xdat), .excl_done(xd), .bank,
    .local_on(lo), .omni_on(om), .mono_on(mo), .ctrl_reset(cr),
    .chan_pressure(cp));
  midi_sink_model sink (.clock, .nrst, .tx_byte_valid(bv), .tx_byte(tb),
    .tx_byte_ready(br), .slow);
  // pulses are counted so a check never hangs on one exact cycle
  always @(posedge clock)
  begin
    nm += mv;
    ns += sv;
    nx += xv;
    nd += xd;
    nr += cr;
    if (xv)
      xl = xdat;
  end
  // ====================
  // bus tasks
  task automatic wait_ready;
    int w;
    begin
      w = 0;
      while (rdy !== 1'b1 && w < 99)
      begin
        @(posedge clock);
        #1 w++;
      end
      `CHK("ready", 1'b1, rdy)
    end
  endtask
  task automatic send(input [3:0] k, c, input [6:0] a, b, input r);
    begin
      wait_ready;
      sink.got.delete();
      kind = k;
      chan = c;
      d1 = a;
      d2 = b;
      rel = r;
      req = 1;
      @(posedge clock);
      #1 req = 0;
      wait_ready;
    end
  endtask
  task automatic got(input int n, input [23:0] e);
    begin
      `CHK("count", n, sink.got.size())
      for (int i = 0; i < n; i++)
        `CHK("byte", e[23-8*i -: 8], sink.got[i])
    end
  endtask
  task automatic msg(input int n, input [63:0] v);
    begin
      nm = 0;
      ns = 0;
      nx = 0;
      nd = 0;
      nr = 0;
      for (int i = 0; i < n; i++)
      begin
        @(posedge clock);
        #1 rv = 1;
        rb = v[63-8*i -: 8];
      end
      @(posedge clock);
      #1 rv = 0;
      repeat (3) @(posedge clock);
      #1;
    end
  endtask
  // ====================
  // scenarios
  task automatic t_tx;
    logic [7:0] b1;
    begin
      `CHK("pitch", 14'h2000, mp)
      `CHK("omni", 1'b1, om)
      send(4'h9, 4'h3, 7'h3C, 7'h40, 0);
      got(3, 24'h933C40);
      send(4'h9, 4'h3, 7'h3C, 7'h41, 0);
      got(2, 24'h3C4100);
      send(4'h8, 4'h3, 7'h3C, 7'h55, 1);
      got(2, 24'h3C0000);
      slow = 1;
      for (int i = 8; i < 15; i++)
      begin
        send(i[3:0], 4'hF, 7'h12, 7'h34, 0);
        b1 = (i == 14) ? 8'h3C : (i == 13) ? 8'h34 : 8'h12;
        got((i == 12 || i == 13) ? 2 : 3,
          {i[3:0], 4'hF, b1, (i == 14) ? 8'h55 : 8'h34});
      end
      slow = 0;
    end
  endtask
  task automatic t_rx;
    begin
      msg(6, 64'h953C40F83C000000);
      `CHK("msgs", 2, nm)
      `CHK("kind", 4'h8, mk)
      `CHK("chan", 4'h5, mc)
      `CHK("key", 7'h3C, m1)
      `CHK("vel", 7'h00, m2)
      `CHK("sys", 8'hF8, ss)
      msg(3, 64'hE07F010000000000);
      `CHK("wheel", 14'h00FF, mp)
      msg(7, 64'hB079007A00200500);
      `CHK("ctlrst", 1, nr)
      `CHK("local", 1'b0, lo)
      `CHK("bank", 14'h0005, bank)
      `CHK("bankflag", 1'b1, mb)
      `CHK("modeflag", 1'b0, mm)
      `CHK("centre", 14'h2000, mp)
      msg(2, 64'h7C00000000000000);
      `CHK("omnioff", 1'b0, om)
      msg(3, 64'h913C400000000000);
      `CHK("ignored", 0, nm)
      msg(5, 64'hB07E007D00000000);
      `CHK("mono", 1'b1, mo)
      `CHK("omnion", 1'b1, om)
      `CHK("mode", 1'b1, mm)
      msg(4, 64'hC005D02700000000);
      `CHK("onebyte", 2, nm)
      `CHK("presskind", 4'hD, mk)
      `CHK("pressval", 7'h27, m1)
      `CHK("chanpress", 7'h27, cp)
      msg(3, 64'h803C220000000000);
      `CHK("offkind", 4'h8, mk)
      `CHK("offvel", 7'h22, m2)
      msg(3, 64'hA03C110000000000);
      `CHK("polykind", 4'hA, mk)
      `CHK("polyval", 7'h11, m2)
      msg(4, 64'hF07D11F700000000);
      `CHK("excl", 7'h11, xl)
      `CHK("done", 1, nd)
      msg(4, 64'hF00122F700000000);
      `CHK("foreign", 0, nx + nd)
    end
  endtask
  task automatic wrap_up;
    begin
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial
  begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    {nrst, req, rel, rv, slow, kind, chan, d1, d2, rb} = 0;
    pitch = 14'h2ABC;
    repeat (20) @(posedge clock);
    #1 nrst = 1;
    t_tx;
    t_rx;
    wrap_up;
  end
  initial
  begin
    #100000;
    errors++;
    wrap_up;
  end
endmodule // midi_channel_message_codec_test
